// ===== plld_top.sv
// Purpose: Lock status, sticky unlock flag, data-out pin and dead zone.
// Assumes: Link pins are sampled by clk_i; AHB-Lite answers with no wait.
// Notes:   Reading the interrupt status register clears it.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.

// Contract
// - The unlock flag stays set after an unlock and clears only at the next serial transaction.
// - In direct lock mode the data-out pin is high while locked and low while unlocked.
// - The two-bit dead-zone field picks modes A and B on/on, and C and D off/off with growing dead zone.
// - In the on/on modes the charge pump emits correction pulses even while locked.
// - The data-out pin can show IF count completion, lock, or an input port pin unchanged.
// - Lock is judged once per reference period, over a whole period.
// - Serial control data is latched when transfer enable falls.
module plld_top
	import plld_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        clk_en_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        xfer_en_i,
	input  wire logic        link_clk_i,
	input  wire logic        data_in_i,
	output logic             data_out_o,
	output logic             data_out_oe_n_o,
	input  wire logic        fref_i,
	input  wire logic        fdiv_i,
	input  wire logic        port_pin_i,
	input  wire logic        if_count_done_i,
	output logic             count_enable_bit_o,
	output logic             cp_up_o,
	output logic             cp_dn_o,
	output logic             charge_pump_on_o,
	output logic             locked_o,
	output logic             irq_o
);
	plld_pins_type pins;
	plld_ctrl_type ctrl_q;
	logic [SER_BITS-1:0] shin_q;
	logic [SER_BITS-1:0] shout_q;
	logic                unlock_flag_q;
	logic                lock_q;
	logic                fp_seen_q;
	logic                err_bad_q;
	logic                fr_lead_q;
	logic                fp_lead_q;
	logic [7:0]          err_cnt_q;
	logic [7:0]          pump_cnt_q;
	logic                up_q;
	logic                dn_q;
	logic [IRQ_BITS-1:0] irq_st_q;
	logic [IRQ_BITS-1:0] irq_msk_q;
	logic                ph_act_q;
	logic                ph_wr_q;
	logic [3:0]          ph_addr_q;

	plld_sync u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.clk_en_i  (clk_en_i),
		.pin_i     ({port_pin_i, fdiv_i, fref_i, data_in_i,
		              link_clk_i, xfer_en_i}),
		.pins_o    (pins)
	);

	wire ce_lvl    = pins.lvl[PIN_CE];
	wire ce_rise   = pins.rise[PIN_CE];
	wire ce_fall   = pins.fall[PIN_CE];
	wire cl_rise   = pins.rise[PIN_CL];
	wire cl_fall   = pins.fall[PIN_CL];
	wire fr_rise   = pins.rise[PIN_FR];
	wire fp_rise   = pins.rise[PIN_FP];
	wire shift_in  = ce_lvl & cl_rise;
	wire shift_out = ce_lvl & cl_fall;

	// Lock judgement at each reference period end.
	wire err_over = err_cnt_q > LOCK_WIN;
	wire period_ok = fp_seen_q & ~err_bad_q & ~err_over;
	wire judge = fr_rise;
	wire unlocked_now = judge & ~period_ok;
	wire relocked_now = judge & period_ok & ~lock_q;

	// Dead zone and charge pump decode.
	wire on_on = ~ctrl_q.dz_sel[1];
	wire [7:0] dz_cyc = (ctrl_q.dz_sel == dead_zone_mode_d) ? DZ_D_CYC :
	                    (ctrl_q.dz_sel == dead_zone_mode_c) ? DZ_C_CYC :
	                    8'h00;
	wire pump_pass = on_on | (pump_cnt_q >= dz_cyc);

	// Bus decode.
	wire bus_take = hsel_i & hready_i & htrans_i[1];
	wire wr_ctrl = ph_act_q & ph_wr_q & (ph_addr_q == ADDR_CTRL);
	wire wr_msk = ph_act_q & ph_wr_q & (ph_addr_q == ADDR_IRQ_MSK);
	wire rd_take = bus_take & ~hwrite_i;
	wire rd_irq = rd_take & (haddr_i[3:0] == ADDR_IRQ_ST);
	wire [31:0] rd_val =
		(haddr_i[3:0] == ADDR_CTRL) ? {27'h0, ctrl_q} :
		(haddr_i[3:0] == ADDR_STATUS) ?
			{29'h0, ctrl_q.dz_sel[1] ^ 1'b1, unlock_flag_q, lock_q} :
		(haddr_i[3:0] == ADDR_IRQ_ST) ? {29'h0, irq_st_q} :
		(haddr_i[3:0] == ADDR_IRQ_MSK) ? {29'h0, irq_msk_q} :
		32'h0000_0000;
	wire [IRQ_BITS-1:0] irq_ev = {ce_fall, relocked_now, unlocked_now};

	// Data-out pin selection; the pin pulls low for a zero.
	logic do_val;
	always_comb begin
		if (ce_lvl) begin
			do_val = shout_q[SER_BITS-1];
		end else begin
			unique case (ctrl_q.do_mode)
				DO_IDLE: begin
					do_val = 1'b1;
				end
				DO_LOCK: begin
					do_val = lock_q;
				end
				DO_IFDONE: begin
					do_val = if_count_done_i;
				end
				DO_PORT: begin
					do_val = pins.lvl[PIN_IO];
				end
			endcase
		end
	end

	// Serial shifting and latch of control data on transfer-enable fall.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			shin_q <= 8'h00;
			shout_q <= 8'h00;
			ctrl_q <= CTRL_RST;
		end else if (clk_en_i) begin
			if (shift_in) begin
				shin_q <= {shin_q[SER_BITS-2:0], pins.lvl[PIN_DI]};
			end
			if (ce_rise) begin
				shout_q <= {unlock_flag_q, if_count_done_i, 6'h00};
			end else if (shift_out) begin
				shout_q <= {shout_q[SER_BITS-2:0], 1'b0};
			end
			if (ce_fall) begin
				ctrl_q <= shin_q[CTRL_BITS-1:0];
			end else if (wr_ctrl) begin
				ctrl_q <= hwdata_i[CTRL_BITS-1:0];
			end
		end
	end

	// Sticky unlock flag: a new unlock beats the transaction clear.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			unlock_flag_q <= 1'b0;
			lock_q <= 1'b0;
		end else if (clk_en_i) begin
			if (unlocked_now) begin
				unlock_flag_q <= 1'b1;
			end else if (ce_rise) begin
				unlock_flag_q <= 1'b0;
			end
			if (judge) begin
				lock_q <= period_ok;
			end
		end
	end

	// Phase error measured between reference and divided edges.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fp_seen_q <= 1'b0;
			err_bad_q <= 1'b0;
			fr_lead_q <= 1'b0;
			fp_lead_q <= 1'b0;
			err_cnt_q <= 8'h00;
		end else if (clk_en_i) begin
			if (fr_rise) begin
				fp_seen_q <= fp_rise;
				err_bad_q <= 1'b0;
				fr_lead_q <= ~fp_rise & ~fp_lead_q;
				fp_lead_q <= 1'b0;
				err_cnt_q <= fp_lead_q ? err_cnt_q : 8'h00;
			end else begin
				if (fp_rise) begin
					err_bad_q <= err_bad_q | fp_seen_q;
					fp_seen_q <= 1'b1;
					fr_lead_q <= 1'b0;
					fp_lead_q <= ~fr_lead_q;
					if (~fr_lead_q) begin
						err_cnt_q <= 8'h00;
					end
				end
				if ((fr_lead_q | fp_lead_q) && err_cnt_q != 8'hff) begin
					err_cnt_q <= err_cnt_q + 8'h01;
				end
			end
		end
	end

	// Charge pump: on/on pulses only the leading side each period, for as long as it leads.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
			pump_cnt_q <= 8'h00;
		end else if (clk_en_i) begin
			if (up_q & dn_q) begin
				up_q <= 1'b0;
				dn_q <= 1'b0;
				pump_cnt_q <= 8'h00;
			end else begin
				up_q <= up_q | fr_rise;
				dn_q <= dn_q | fp_rise;
				if ((up_q | dn_q) && pump_cnt_q != 8'hff) begin
					pump_cnt_q <= pump_cnt_q + 8'h01;
				end else if (~(up_q | dn_q)) begin
					pump_cnt_q <= 8'h00;
				end
			end
		end
	end

	// Bus slave with interrupt status, mask and registered outputs.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ph_act_q <= 1'b0;
			ph_wr_q <= 1'b0;
			ph_addr_q <= 4'h0;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			irq_st_q <= 3'h0;
			irq_msk_q <= 3'h0;
			irq_o <= 1'b0;
		end else if (clk_en_i) begin
			ph_act_q <= bus_take;
			ph_wr_q <= hwrite_i;
			ph_addr_q <= haddr_i[3:0];
			if (rd_take) begin
				hrdata_o <= rd_val;
			end
			if (rd_irq) begin
				irq_st_q <= irq_ev;
			end else begin
				irq_st_q <= irq_st_q | irq_ev;
			end
			if (wr_msk) begin
				irq_msk_q <= hwdata_i[IRQ_BITS-1:0];
			end
			irq_o <= |(irq_st_q & irq_msk_q);
		end
	end

	// Pin and status outputs, all from flops.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			data_out_o <= 1'b0;
			data_out_oe_n_o <= 1'b1;
			count_enable_bit_o <= 1'b0;
			cp_up_o <= 1'b0;
			cp_dn_o <= 1'b0;
			charge_pump_on_o <= 1'b1;
			locked_o <= 1'b0;
		end else if (clk_en_i) begin
			data_out_o <= 1'b0;
			data_out_oe_n_o <= do_val;
			count_enable_bit_o <= ctrl_q.count_enable_bit;
			cp_up_o <= up_q & ~dn_q & pump_pass;
			cp_dn_o <= dn_q & ~up_q & pump_pass;
			charge_pump_on_o <= on_on;
			locked_o <= lock_q;
		end
	end
endmodule : plld_top

// ===== plld_pkg.sv
// Purpose: Shared constants and types, and the pin synchroniser.
// Assumes: One 100 MHz clock; every synchronised pin is asynchronous to it.
// Notes:   The synchroniser also flags rising and falling edges.
package plld_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h4;
	localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MSK = 4'hc;
	localparam int SER_BITS = 8;
	localparam int CTRL_BITS = 5;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam int IRQ_BITS = 3;
	localparam int IRQ_UNLOCK = 0;
	localparam int IRQ_RELOCK = 1;
	localparam int IRQ_LATCH = 2;
	// Phase error in clock cycles still judged as locked.
	localparam logic [7:0] LOCK_WIN = 8'h04;
	// Extra cycles of dead zone in the two off/off modes.
	localparam logic [7:0] DZ_C_CYC = 8'h02;
	localparam logic [7:0] DZ_D_CYC = 8'h06;
	localparam int PIN_CE = 0;
	localparam int PIN_CL = 1;
	localparam int PIN_DI = 2;
	localparam int PIN_FR = 3;
	localparam int PIN_FP = 4;
	localparam int PIN_IO = 5;
	localparam int PIN_N = 6;

	typedef enum logic [1:0] {
		no_dead_zone_mode_a = 2'b00,
		no_dead_zone_mode_b = 2'b01,
		dead_zone_mode_c    = 2'b10,
		dead_zone_mode_d    = 2'b11
	} plld_dz_type;

	typedef enum logic [1:0] {
		DO_IDLE   = 2'b00,
		DO_LOCK   = 2'b01,
		DO_IFDONE = 2'b10,
		DO_PORT   = 2'b11
	} plld_do_type;

	typedef struct packed {
		logic        count_enable_bit;
		plld_do_type do_mode;
		plld_dz_type dz_sel;
	} plld_ctrl_type;

	typedef struct packed {
		logic [PIN_N-1:0] lvl;
		logic [PIN_N-1:0] rise;
		logic [PIN_N-1:0] fall;
	} plld_pins_type;
endpackage : plld_pkg

module plld_sync
	import plld_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             clk_en_i,
	input  wire logic [PIN_N-1:0] pin_i,
	output plld_pins_type         pins_o
);
	logic [PIN_N-1:0] meta_q;
	logic [PIN_N-1:0] sync_q;
	logic [PIN_N-1:0] last_q;

	// Two flops per pin, then an edge stage that only reads the second.
	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				meta_q[i] <= 1'b0;
				sync_q[i] <= 1'b0;
				last_q[i] <= 1'b0;
			end else if (clk_en_i) begin
				meta_q[i] <= pin_i[i];
				sync_q[i] <= meta_q[i];
				last_q[i] <= sync_q[i];
			end
		end
		assign pins_o.lvl[i]  = sync_q[i];
		assign pins_o.rise[i] = sync_q[i] & ~last_q[i];
		assign pins_o.fall[i] = ~sync_q[i] & last_q[i];
	end
endmodule : plld_sync

// ===== plld_top_assertions.sv
// Purpose: Port level checks for plld_top.
// Assumes: One clock domain with a synchronous reset.
// Notes:   Bound into every plld_top below the module.
module plld_top_chk (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic        xfer_en_i,
	input wire logic        fref_i,
	input wire logic        data_out_o,
	input wire logic        data_out_oe_n_o,
	input wire logic        count_enable_bit_o,
	input wire logic        cp_up_o,
	input wire logic        cp_dn_o,
	input wire logic        charge_pump_on_o,
	input wire logic        locked_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [3:0] qc_q;
	logic [3:0] fa_q;
	// Cycles with no serial frame and no bus write.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || xfer_en_i || (hsel_i && hwrite_i))
			qc_q <= 4'h0;
		else if (qc_q != 4'hf)
			qc_q <= qc_q + 4'h1;
	end
	// Cycles since the reference pin last rose.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			fa_q <= 4'hf;
		else if ($rose(fref_i))
			fa_q <= 4'h0;
		else if (fa_q != 4'hf)
			fa_q <= fa_q + 4'h1;
	end
	sequence s_st_rd;
		hsel_i && htrans_i[1] && !hwrite_i && haddr_i[3:0] == 4'h4;
	endsequence
	chk_bus_okay: assert property (!hresp_o && hreadyout_o)
		else $error("bus answer not OKAY without wait");
	chk_od_low: assert property (data_out_o == 1'b0)
		else $error("open drain value not low");
	chk_pump_excl: assert property (!(cp_up_o && cp_dn_o))
		else $error("both pump pulses high");
	chk_ctrl_quiet: assert property (
		qc_q > 4'h8 |-> $stable(charge_pump_on_o))
		else $error("pump mode changed with no latch");
	chk_cnt_quiet: assert property (
		qc_q > 4'h8 |-> $stable(count_enable_bit_o))
		else $error("count enable changed with no latch");
	chk_lock_cadence: assert property (
		$changed(locked_o) |-> fa_q < 4'ha)
		else $error("lock changed away from period end");
	chk_status_lock: assert property (
		s_st_rd |=> hrdata_o[0] == locked_o &&
			hrdata_o[2] == charge_pump_on_o)
		else $error("status read disagrees with pins");
	chk_reset_vals: assert property (disable iff (1'b0)
		sys_rst_i |=> data_out_oe_n_o && !locked_o && !irq_o &&
			charge_pump_on_o && !count_enable_bit_o)
		else $error("wrong value after reset");
endmodule : plld_top_chk

bind plld_top plld_top_chk plld_top_chk_inst (.*);

// ===== plld_ctl_model.sv
// Purpose: System controller side of the three wire serial link.
// Assumes: Link clock stands low outside frames.
// Notes:   Half period is chosen per frame, prompt or slow.
module plld_ctl_model (
	output logic ce_o,
	output logic cl_o,
	output logic di_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ce_o = 1'b0;
		cl_o = 1'b0;
		di_o = 1'b0;
	end
	task automatic send(input logic [7:0] b, input int hp);
		#3 ce_o = 1'b1;
		#(2 * hp);
		for (int i = 7; i >= 0; i--) begin
			di_o = b[i];
			#hp cl_o = 1'b1;
			#hp cl_o = 1'b0;
		end
		#hp ce_o = 1'b0;
		di_o = ~di_o;
		#(2 * hp);
	endtask : send
endmodule : plld_ctl_model

// ===== tb.sv
// Purpose: Self checking bench for plld_top.
// Assumes: Single slave, so hready follows hreadyout.
// Notes:   Reference period is 40 clock cycles.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, sys_rst_i, clk_en_i, hsel_i, hwrite_i, hready_i;
	logic hreadyout_o, hresp_o, xfer_en_i, link_clk_i, data_in_i;
	logic data_out_o, data_out_oe_n_o, fref_i, fdiv_i, port_pin_i;
	logic if_count_done_i, count_enable_bit_o, cp_up_o, cp_dn_o;
	logic charge_pump_on_o, locked_o, irq_o, run, p;
	logic [1:0]  htrans_i;
	logic [2:0]  hsize_i;
	logic [5:0]  rc = 6'h00;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
	int          failures, n_tests;
	logic [5:0]  rows [4] = '{6'h20, 6'h35, 6'h1a, 6'h0f};
	logic [7:0]  mv [2] = '{8'h0c, 8'h18};
	assign hready_i = hreadyout_o;
	plld_top plld_top_inst (.*);
	plld_ctl_model plld_ctl_model_inst (.ce_o(xfer_en_i), .cl_o(link_clk_i),
		.di_o(data_in_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		rc <= (rc == 6'd39) ? 6'd0 : rc + 6'd1;
		fref_i <= rc < 6'd20;
		fdiv_i <= run & fref_i;
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic test_done;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic wt;
		int i;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (hreadyout_o !== 1'b1 && i < 50);
		if (i >= 50) begin
			failures++;
			test_done;
		end
	endtask : wt
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i <= {28'h0, a};
		hwrite_i <= w;
		wt;
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		wt;
		r = hrdata_o;
	endtask : bus
	task automatic wl(input logic v);
		int i;
		for (i = 0; i < 3000 && locked_o !== v; i++)
			@(posedge clk_i);
		if (i >= 3000) begin
			failures++;
			test_done;
		end
		repeat (3) @(posedge clk_i);
	endtask : wl
	initial begin
		{sys_rst_i, clk_en_i, run, hsel_i, hwrite_i} = 5'h18;
		{port_pin_i, if_count_done_i} = 2'h0;
		{htrans_i, hsize_i, haddr_i, hwdata_i} = {2'h0, 3'h2, 64'h0};
		{failures, n_tests} = 0;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		chk("oe_n_rst", 1, data_out_oe_n_o);
		foreach (rows[k]) begin
			bus(1, 4'h0, {27'h0, rows[k][4:0]});
			bus(0, 4'h0, 0);
			chk("ctrl", rows[k][4:0], r[4:0]);
			bus(0, 4'h4, 0);
			chk("pump_st", rows[k][5], r[2]);
			chk("pump_pin", rows[k][5], charge_pump_on_o);
			chk("cnt_en", rows[k][4], count_enable_bit_o);
		end
		bus(1, 4'hc, 0);
		run <= 1'b1;
		wl(1);
		repeat (80) @(posedge clk_i);
		plld_ctl_model_inst.send(8'h04, 80);
		bus(0, 4'h0, 0);
		chk("ctrl_ser", 5'h04, r[4:0]);
		chk("do_lock", 1, data_out_oe_n_o);
		p = 1'b0;
		repeat (200) begin
			@(posedge clk_i);
			p |= cp_up_o | cp_dn_o;
		end
		chk("pulses", 1, p);
		run <= 1'b0;
		wl(0);
		chk("do_unlock", 0, data_out_oe_n_o);
		chk("irq_masked", 0, irq_o);
		bus(0, 4'h4, 0);
		chk("flag", 1, r[1]);
		bus(1, 4'hc, 32'h3);
		repeat (3) @(posedge clk_i);
		chk("irq_on", 1, irq_o);
		run <= 1'b1;
		wl(1);
		repeat (80) @(posedge clk_i);
		bus(0, 4'h4, 0);
		chk("flag_sticky", 1, r[1]);
		bus(0, 4'h8, 0);
		chk("irq_st", 2'b11, r[1:0]);
		repeat (3) @(posedge clk_i);
		chk("irq_clr", 0, irq_o);
		// The bus reads above leave the flag set; the rise of transfer enable in a frame clears it.
		plld_ctl_model_inst.send(8'h0c, 80);
		bus(0, 4'h4, 0);
		chk("flag_clr", 0, r[1]);
		// The port pin carries station detect; count is enabled after it.
		foreach (mv[j]) begin
			plld_ctl_model_inst.send(mv[j], 80);
			@(posedge clk_i);
			for (int v = 0; v < 2; v++) begin
				{port_pin_i, if_count_done_i} <= {2{v[0]}};
				repeat (8) @(posedge clk_i);
				chk("do_pin", v[0], data_out_oe_n_o);
			end
		end
		chk("cnt_ser", 1, count_enable_bit_o);
		// A reset in mid run returns control and lock to idle.
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		chk("rst_cnt", 0, count_enable_bit_o);
		chk("rst_lock", 0, locked_o);
		bus(0, 4'h0, 0);
		chk("rst_ctrl", 0, r[4:0]);
		wl(1);
		test_done;
	end
endmodule : tb
